// [verilog/bpa_pkg.sv]
// Purpose: Shared constants and types for the backplane bus priority arbiter.
// Assumes: One 50 MHz clock, synchronous active-low reset.
// Notes: Level 3 is the top level; level 0 is the lowest.
package bpa_pkg;

  localparam int unsigned BPA_LEVELS = 4;
  localparam int unsigned BPA_LVL_W = 2;
  localparam logic [1:0] BPA_TOP_LEVEL = 2'h3;
  localparam int unsigned BPA_SYNC_STAGES = 3;
  localparam logic [3:0] BPA_GRANT_NONE = 4'h0;

  typedef enum logic [2:0] {
    BPA_IDLE  = 3'h1,
    BPA_GRANT = 3'h2,
    BPA_BUSY  = 3'h4
  } bpa_state_t;

endpackage : bpa_pkg

// [verilog/bpa_arbiter.sv]
// Purpose: System-controller arbiter for a backplane bus with four request levels.
// Assumes: Requests and bus-busy arrive from the backplane and are asynchronous.
// Notes: Grants leave on one daisy chain per level; boards gate them onward.
`timescale 1ns/1ps
`default_nettype none

module bpa_arbiter
  import bpa_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Mode
  input wire logic single_level_i,
  // Backplane arbitration pins
  input wire logic [3:0] bus_req_i,
  input wire logic bus_busy_i,
  output logic [3:0] bus_grant_o,
  output logic bus_clear_o,
  // Status
  output logic [1:0] owner_level_o
);

  // Three stages; a change counts once the second and third stage agree.
  // The agreement check costs a cycle of latency, but a single noisy sample
  // on a backplane line can never reach the grant logic.
  logic [3:0] req_s1_reg, req_s2_reg, req_s3_reg, req_reg;
  logic busy_s1_reg, busy_s2_reg, busy_s3_reg, busy_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      req_s1_reg <= 4'h0;
      req_s2_reg <= 4'h0;
      req_s3_reg <= 4'h0;
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
      busy_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= bus_req_i;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      busy_s1_reg <= bus_busy_i;
      busy_s2_reg <= busy_s1_reg;
      busy_s3_reg <= busy_s2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < BPA_LEVELS; g++) begin : g_filt
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          req_reg[g] <= 1'b0;
        end else if (req_s2_reg[g] == req_s3_reg[g]) begin
          req_reg[g] <= req_s3_reg[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
    end else if (busy_s2_reg == busy_s3_reg) begin
      busy_reg <= busy_s3_reg;
    end
  end

  // In single-level mode every board is strapped to the top level, so any
  // request is folded onto that level and position alone decides.
  wire logic any_req = |req_reg;
  wire logic [3:0] eff_req = single_level_i ? {any_req, 3'h0} : req_reg;

  // Pick the highest pending level; slots never enter this decision.
  wire logic [1:0] win_level = eff_req[3] ? 2'h3 :
                               eff_req[2] ? 2'h2 :
                               eff_req[1] ? 2'h1 : 2'h0;

  bpa_state_t state_reg, state_next;
  logic [1:0] owner_reg, owner_next;
  logic [3:0] grant_reg, grant_next;
  logic clear_reg, clear_next;

  always_comb begin
    state_next = state_reg;
    owner_next = owner_reg;
    grant_next = grant_reg;
    unique case (state_reg)
      BPA_IDLE: begin
        // Wait for the bus to be free before granting again.
        if (any_req && !busy_reg) begin
          owner_next = win_level;
          grant_next = 4'h1 << win_level;
          state_next = BPA_GRANT;
        end else if (busy_reg) begin
          // A board can drop its request a cycle before its busy is seen, so
          // the grant is withdrawn early; the bus is still owned, and bus
          // clear must still be able to reach that owner.
          state_next = BPA_BUSY;
        end
      end
      BPA_GRANT: begin
        // Hold the grant until the winner takes the bus, or the request vanishes.
        if (busy_reg || !eff_req[owner_reg]) begin
          grant_next = BPA_GRANT_NONE;
          state_next = busy_reg ? BPA_BUSY : BPA_IDLE;
        end
      end
      BPA_BUSY: begin
        // The owner may run a whole block tenure; only its release ends it.
        if (!busy_reg) begin
          state_next = BPA_IDLE;
        end
      end
      default: begin
        state_next = BPA_IDLE;
        grant_next = BPA_GRANT_NONE;
      end
    endcase
  end

  // Higher-level waiters ask the owner to let go after its current cycle.
  wire logic higher_wait = (eff_req >> owner_reg) > 4'h1;
  assign clear_next = (state_reg == BPA_BUSY) && busy_reg && higher_wait;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= BPA_IDLE;
      owner_reg <= BPA_TOP_LEVEL;
      grant_reg <= BPA_GRANT_NONE;
      clear_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      owner_reg <= owner_next;
      grant_reg <= grant_next;
      clear_reg <= clear_next;
    end
  end

  assign bus_grant_o = grant_reg;
  assign bus_clear_o = clear_reg;
  assign owner_level_o = owner_reg;

  // Steps of one tenure, shared by the properties below.
  sequence bus_free_req_s;
    (state_reg == BPA_IDLE) && any_req && !busy_reg;
  endsequence

  sequence grant_taken_s;
    (state_reg == BPA_GRANT) && busy_reg;
  endsequence

  sequence owner_gone_s;
    (state_reg == BPA_BUSY) && !busy_reg && any_req;
  endsequence

  one_grant_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $onehot0(bus_grant_o)) else $error("More than one grant chain driven.");

  grant_level_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    bus_free_req_s |=> (bus_grant_o == (4'h1 << $past(win_level))))
    else $error("Grant not on winning level.");

  no_lower_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_reg == BPA_IDLE && eff_req[3] && !busy_reg) |=> bus_grant_o[3])
    else $error("Top level request lost to lower level.");

  single_top_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    single_level_i && $stable(single_level_i) |-> (bus_grant_o[2:0] == 3'h0))
    else $error("Lower grant line used in single-level mode.");

  busy_no_grant_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_reg == BPA_BUSY) |-> bus_grant_o == BPA_GRANT_NONE)
    else $error("Grant issued while bus is owned.");

  clear_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    bus_clear_o |-> $past(busy_reg) && $past(higher_wait))
    else $error("Bus clear without a higher waiter.");

  clear_raise_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_reg == BPA_BUSY && busy_reg && higher_wait) |=> bus_clear_o)
    else $error("Bus clear not raised for higher waiter.");

  release_regrant_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    owner_gone_s |=> ##1 ((bus_grant_o != BPA_GRANT_NONE) || busy_reg))
    else $error("No grant after release with waiters.");

  grant_owner_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (bus_grant_o != BPA_GRANT_NONE) |-> (bus_grant_o == (4'h1 << owner_level_o)))
    else $error("Grant line and owner level disagree.");

  grant_stand_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ((state_reg == BPA_GRANT) && !busy_reg && eff_req[owner_reg]) |=> $stable(bus_grant_o))
    else $error("Grant dropped while still wanted.");

  grant_taken_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    grant_taken_s |=> (state_reg == BPA_BUSY) && (bus_grant_o == BPA_GRANT_NONE))
    else $error("Grant kept after the bus was taken.");

  clear_owned_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    bus_clear_o |-> (state_reg == BPA_BUSY) && (bus_grant_o == BPA_GRANT_NONE))
    else $error("Bus clear outside an owned tenure.");

  busy_owned_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ((state_reg == BPA_IDLE) && busy_reg) |=> (state_reg == BPA_BUSY))
    else $error("Owned bus not tracked as busy.");

endmodule // bpa_arbiter

`default_nettype wire

// [tb/bpa_board_model.sv]
// Purpose: Master board on the backplane that takes and releases the bus.
// Assumes: Holds the bus for a block of HOLD+1 cycles.
// Notes: Gives the bus up early once bus clear is seen.
`timescale 1ns/1ps
`default_nettype none
module bpa_board_model
  import bpa_pkg::*;
#(parameter int HOLD = 30)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Bench side
  input wire logic [3:0] want_i,
  // Arbiter side
  input wire logic [3:0] bus_grant_i,
  input wire logic bus_clear_i,
  output logic [3:0] bus_req_o,
  output logic bus_busy_o
);
  logic [3:0] done_reg;
  logic [7:0] cnt_reg;
  logic take;
  // Slave-only slots never request, so they simply own no bit here.
  assign bus_req_o = want_i & ~done_reg;
  assign take = (|(bus_grant_i & bus_req_o)) && !bus_busy_o;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      done_reg <= 4'h0;
      bus_busy_o <= 1'b0;
      cnt_reg <= 8'h0;
    end else begin
      done_reg <= (done_reg | (take ? bus_grant_i : 4'h0)) & want_i;
      cnt_reg <= take ? 8'h0 : cnt_reg + 8'h1;
      if (take) begin
        bus_busy_o <= 1'b1;
      end else if (cnt_reg == 8'(HOLD) || (bus_clear_i && cnt_reg > 8'h2)) begin
        bus_busy_o <= 1'b0;
      end
    end
  end
endmodule // bpa_board_model
`default_nettype wire

// [tb/bpa_arbiter_tb.sv]
// Purpose: Self-checking bench for the arbiter.
// Assumes: One board model answers every grant.
// Notes: Grants are awaited with a bound, since requests are synchronised.
`timescale 1ns/1ps
`default_nettype none
module bpa_arbiter_tb;
  import bpa_pkg::*;
  logic ref_clk_i, rst_n_i, single_level_i, bus_busy_i, bus_clear_o;
  logic [3:0] want, bus_req_i, bus_grant_o;
  logic [1:0] owner_level_o;
  int miscompares, num_checks;
  bpa_arbiter u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .single_level_i(single_level_i), .bus_req_i(bus_req_i), .bus_busy_i(bus_busy_i),
    .bus_grant_o(bus_grant_o), .bus_clear_o(bus_clear_o), .owner_level_o(owner_level_o));
  bpa_board_model u_brd (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .want_i(want),
    .bus_grant_i(bus_grant_o), .bus_clear_i(bus_clear_o), .bus_req_o(bus_req_i),
    .bus_busy_o(bus_busy_i));
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [3:0] pick(input int sel);
    return sel ? {3'h0, bus_clear_o} : bus_grant_o;
  endfunction
  task automatic wait_for(input string nm, input int sel, input logic [3:0] exp);
    @(negedge ref_clk_i);
    for (int i = 0; i < 40 && pick(sel) !== exp; i++) @(negedge ref_clk_i);
    chk(nm, exp, pick(sel));
  endtask
  task automatic drain();
    @(posedge ref_clk_i) want <= 4'h0;
    for (int i = 0; i < 60 && (bus_busy_i !== 1'b0 || bus_grant_o !== 4'h0); i++)
      @(negedge ref_clk_i);
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic t_reset();
    @(negedge ref_clk_i);
    chk("grant", 4'h0, bus_grant_o);
    chk("clear", 4'h0, {3'h0, bus_clear_o});
    chk("owner", {2'h0, BPA_TOP_LEVEL}, {2'h0, owner_level_o});
  endtask
  task automatic t_one();
    @(posedge ref_clk_i) want <= 4'h4;
    wait_for("grant", 0, 4'h4);
    chk("owner", 4'h2, {2'h0, owner_level_o});
    drain();
  endtask
  task automatic t_levels();
    @(posedge ref_clk_i) want <= 4'h1;
    wait_for("grant", 0, 4'h1);
    @(posedge ref_clk_i) want <= 4'hB;
    wait_for("clear", 1, 4'h1);
    wait_for("grant", 0, 4'h8);
    chk("owner", 4'h3, {2'h0, owner_level_o});
    wait_for("grant", 0, 4'h0);
    wait_for("grant", 0, 4'h2);
    chk("owner", 4'h1, {2'h0, owner_level_o});
    drain();
  endtask
  task automatic t_single();
    @(posedge ref_clk_i) single_level_i <= 1'b1;
    want <= 4'h8;
    wait_for("grant", 0, 4'h8);
    chk("owner", 4'h3, {2'h0, owner_level_o});
    wait_for("grant", 0, 4'h0);
    @(posedge ref_clk_i) want <= 4'h0;
    @(posedge ref_clk_i) want <= 4'h8;
    repeat (8) @(negedge ref_clk_i);
    chk("clear", 4'h0, {3'h0, bus_clear_o});
    wait_for("grant", 0, 4'h8);
    drain();
  endtask
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    rst_n_i = 1'b0;
    single_level_i = 1'b0;
    want = 4'h0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_one();
    t_levels();
    t_single();
    finish_test();
  end
endmodule // bpa_arbiter_tb
`default_nettype wire
